// ### shared/par_defs.svh
`ifndef PAR_DEFS_SVH
`define PAR_DEFS_SVH

// ==========================================================
// register byte offsets
`define PAR_OFF_START     12'h000
`define PAR_OFF_STOP      12'h008
`define PAR_OFF_EV_END    12'h100
`define PAR_OFF_EV_MATCH  12'h104
`define PAR_OFF_EV_NOHIT  12'h108
`define PAR_OFF_MASKSET   12'h304
`define PAR_OFF_MASKCLR   12'h308
`define PAR_OFF_STATUS    12'h400
`define PAR_OFF_ENABLE    12'h500
`define PAR_OFF_KEYCNT    12'h504
`define PAR_OFF_KEYPTR    12'h508
`define PAR_OFF_TARGET_ADDRESS_POINTER   12'h510
`define PAR_OFF_TEMPPTR   12'h514

// ==========================================================
// field positions and values
`define PAR_EV_END        0
`define PAR_EV_MATCH      1
`define PAR_EV_NOHIT      2
`define PAR_ENABLE_ON     2'h3
`define PAR_ENABLE_OFF    2'h0
`define PAR_KEYCNT_RST    5'h01
`define PAR_KEY_BYTES_LOG 4

// ==========================================================
// timing, in ns and derived cycles
`define PAR_CLK_NS        100
`define PAR_SETUP_NS      1000
`define PAR_KEY_NS        5875
`define PAR_SETUP_CYC     ((`PAR_SETUP_NS + `PAR_CLK_NS - 1) / `PAR_CLK_NS)
`define PAR_KEY_CYC       (`PAR_KEY_NS / `PAR_CLK_NS)

`endif

// ### shared/par_pkg.sv
`default_nettype none

package par_pkg;

    // ==========================================================
    // resolver sequencing states
    typedef enum logic [2:0] {
        PAR_ST_IDLE  = 3'b001,
        PAR_ST_SETUP = 3'b010,
        PAR_ST_CHECK = 3'b100
    } par_state_t;

    typedef logic [4:0] par_keyidx_t;

    // ==========================================================
    // one key check handed to the matcher
    typedef struct packed {
        logic [31:0] keyAddr;
        logic [31:0] target_address_pointer;
        logic [31:0] tempPtr;
    } par_chk_req_t;

endpackage

`default_nettype wire

// ### hw/par_slot_timer.sv
`timescale 1ns/1ns
`default_nettype none

module par_slot_timer (
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    input  wire logic        load,
    input  wire logic [15:0] loadCount,
    output logic             expired
);

    logic [15:0] count_reg;

    // ==========================================================
    // down counter, reload wins over counting
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            count_reg <= 16'h0000;
        end else if (load) begin
            count_reg <= loadCount;
        end else if (count_reg != 16'h0000) begin
            count_reg <= count_reg - 16'h0001;
        end
    end

    // one-cycle pulse as the count runs out
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            expired <= 1'b0;
        end else begin
            expired <= (count_reg == 16'h0001) && !load;
        end
    end

endmodule // par_slot_timer

`default_nettype wire

// ### hw/par_resolver_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "par_defs.svh"

module par_resolver_top #(
    parameter int SETUP_CYC = `PAR_SETUP_CYC,
    parameter int KEY_CYC   = `PAR_KEY_CYC
) (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    output logic                      irq,
    output logic                      chkReq,
    output par_pkg::par_chk_req_t     chkData,
    input  wire logic                 chkDone,
    input  wire logic                 chkMatch
);

    // ==========================================================
    // declarations
    par_pkg::par_state_t  state_reg;
    par_pkg::par_state_t  state_next;
    par_pkg::par_keyidx_t keyIdx_reg;
    par_pkg::par_keyidx_t keyCount_reg;
    logic [3:0]           status_reg;
    logic [1:0]           enable_reg;
    logic [31:0]          keyPtr_reg;
    logic [31:0]          target_address_pointer_reg;
    logic [31:0]          tempPtr_reg;
    logic [2:0]           event_reg;
    logic [2:0]           mask_reg;
    logic [2:0]           evSet;
    logic [2:0]           evClr;
    logic                 slotOver_reg;
    logic                 answered_reg;
    logic                 matchSeen_reg;
    logic                 tmrLoad;
    logic [15:0]          tmrCount;
    logic                 tmrExpired;
    logic                 wrEn;
    logic                 rdSetup;
    logic                 startHit;
    logic                 stopHit;
    logic                 running;
    logic                 nextKey;
    logic [31:0]          rdValue;
    logic                 rdMapped;
    logic [15:0]          setupCnt_reg;

    // register select, shared by the read and write paths
    function automatic logic regHit(input logic [11:0] a, input logic [11:0] off);
        regHit = (a[11:2] == off[11:2]);
    endfunction

    // ==========================================================
    // apb slave: read data captured in setup, write data and answer in first access cycle
    assign rdSetup  = psel && !penable && !pready;
    assign wrEn     = psel && penable && pready && pwrite;
    assign startHit = wrEn && regHit(paddr, `PAR_OFF_START) && pwdata[0];
    assign stopHit  = wrEn && regHit(paddr, `PAR_OFF_STOP) && pwdata[0];
    assign running  = (enable_reg == `PAR_ENABLE_ON);

    // read mux, unmapped addresses flagged
    always_comb begin
        rdValue  = 32'h0000_0000;
        rdMapped = 1'b1;
        if (regHit(paddr, `PAR_OFF_START) || regHit(paddr, `PAR_OFF_STOP)) begin
            rdValue = 32'h0000_0000;
        end else if (regHit(paddr, `PAR_OFF_EV_END)) begin
            rdValue = {31'h0000_0000, event_reg[`PAR_EV_END]};
        end else if (regHit(paddr, `PAR_OFF_EV_MATCH)) begin
            rdValue = {31'h0000_0000, event_reg[`PAR_EV_MATCH]};
        end else if (regHit(paddr, `PAR_OFF_EV_NOHIT)) begin
            rdValue = {31'h0000_0000, event_reg[`PAR_EV_NOHIT]};
        end else if (regHit(paddr, `PAR_OFF_MASKSET)
                     || regHit(paddr, `PAR_OFF_MASKCLR)) begin
            rdValue = {29'h0000_0000, mask_reg};
        end else if (regHit(paddr, `PAR_OFF_STATUS)) begin
            rdValue = {28'h000_0000, status_reg};
        end else if (regHit(paddr, `PAR_OFF_ENABLE)) begin
            rdValue = {30'h0000_0000, enable_reg};
        end else if (regHit(paddr, `PAR_OFF_KEYCNT)) begin
            rdValue = {27'h000_0000, keyCount_reg};
        end else if (regHit(paddr, `PAR_OFF_KEYPTR)) begin
            rdValue = keyPtr_reg;
        end else if (regHit(paddr, `PAR_OFF_TARGET_ADDRESS_POINTER)) begin
            rdValue = target_address_pointer_reg;
        end else if (regHit(paddr, `PAR_OFF_TEMPPTR)) begin
            rdValue = tempPtr_reg;
        end else begin
            rdMapped = 1'b0;
        end
    end

    // answer flops; pready high for exactly the first access cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= rdSetup;
            pslverr <= rdSetup && !rdMapped;
            if (rdSetup) begin
                prdata <= pwrite ? 32'h0000_0000 : rdValue;
            end
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_reg   <= `PAR_ENABLE_OFF;
            keyCount_reg <= `PAR_KEYCNT_RST;
            keyPtr_reg   <= 32'h0000_0000;
            target_address_pointer_reg  <= 32'h0000_0000;
            tempPtr_reg  <= 32'h0000_0000;
        end else if (wrEn) begin
            if (regHit(paddr, `PAR_OFF_ENABLE)) begin
                enable_reg <= pwdata[1:0];
            end
            if (regHit(paddr, `PAR_OFF_KEYCNT)) begin
                keyCount_reg <= pwdata[4:0];
            end
            if (regHit(paddr, `PAR_OFF_KEYPTR)) begin
                keyPtr_reg <= pwdata;
            end
            if (regHit(paddr, `PAR_OFF_TARGET_ADDRESS_POINTER)) begin
                target_address_pointer_reg <= pwdata;
            end
            if (regHit(paddr, `PAR_OFF_TEMPPTR)) begin
                tempPtr_reg <= pwdata;
            end
        end
    end

    // interrupt enables; set and clear sit at different offsets
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            mask_reg <= 3'h0;
        end else if (wrEn && regHit(paddr, `PAR_OFF_MASKSET)) begin
            mask_reg <= mask_reg | pwdata[2:0];
        end else if (wrEn && regHit(paddr, `PAR_OFF_MASKCLR)) begin
            mask_reg <= mask_reg & ~pwdata[2:0];
        end
    end

    // ==========================================================
    // events: write one clears, a new event in the same cycle wins
    assign evClr[`PAR_EV_END]   = wrEn && regHit(paddr, `PAR_OFF_EV_END) && pwdata[0];
    assign evClr[`PAR_EV_MATCH] = wrEn && regHit(paddr, `PAR_OFF_EV_MATCH) && pwdata[0];
    assign evClr[`PAR_EV_NOHIT] = wrEn && regHit(paddr, `PAR_OFF_EV_NOHIT) && pwdata[0];

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            event_reg <= 3'h0;
        end else begin
            event_reg <= evSet | (event_reg & ~evClr);
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(event_reg & mask_reg);
        end
    end

    // ==========================================================
    // sequencer
    always_comb begin
        state_next = state_reg;
        tmrLoad    = 1'b0;
        tmrCount   = 16'(KEY_CYC);
        evSet      = 3'h0;
        nextKey    = 1'b0;
        unique case (state_reg)
            par_pkg::PAR_ST_IDLE: begin
                if (startHit && running) begin
                    state_next = par_pkg::PAR_ST_SETUP;
                    tmrLoad    = 1'b1;
                    tmrCount   = 16'(SETUP_CYC);
                end
            end
            par_pkg::PAR_ST_SETUP: begin
                if (tmrExpired) begin
                    if (keyCount_reg == 5'h00) begin
                        state_next = par_pkg::PAR_ST_IDLE;
                        evSet      = 3'b101;
                    end else begin
                        state_next = par_pkg::PAR_ST_CHECK;
                        tmrLoad    = 1'b1;
                    end
                end
            end
            par_pkg::PAR_ST_CHECK: begin
                if (slotOver_reg && answered_reg) begin
                    if (matchSeen_reg) begin
                        state_next = par_pkg::PAR_ST_IDLE;
                        evSet      = 3'b011;
                    end else if (5'(keyIdx_reg + 5'h01) >= keyCount_reg) begin
                        state_next = par_pkg::PAR_ST_IDLE;
                        evSet      = 3'b101;
                    end else begin
                        nextKey = 1'b1;
                        tmrLoad = 1'b1;
                    end
                end
            end
        endcase
        if (stopHit || !running) begin
            state_next = par_pkg::PAR_ST_IDLE;
            evSet      = 3'h0;
            nextKey    = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= par_pkg::PAR_ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // key index and per-slot flags
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            keyIdx_reg    <= 5'h00;
            slotOver_reg  <= 1'b0;
            answered_reg  <= 1'b0;
            matchSeen_reg <= 1'b0;
        end else if (state_reg != par_pkg::PAR_ST_CHECK || nextKey) begin
            if (state_reg == par_pkg::PAR_ST_IDLE) begin
                keyIdx_reg <= 5'h00;
            end else if (nextKey) begin
                keyIdx_reg <= 5'(keyIdx_reg + 5'h01);
            end
            slotOver_reg  <= 1'b0;
            answered_reg  <= 1'b0;
            matchSeen_reg <= 1'b0;
        end else begin
            if (tmrExpired) begin
                slotOver_reg <= 1'b1;
            end
            if (chkDone && !answered_reg && !chkReq) begin
                answered_reg  <= 1'b1;
                matchSeen_reg <= chkMatch;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= 4'h0;
        end else if (evSet[`PAR_EV_MATCH]) begin
            status_reg <= keyIdx_reg[3:0];
        end
    end

    // matcher request, one pulse per key slot
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            chkReq  <= 1'b0;
            chkData <= '0;
        end else begin
            chkReq <= tmrLoad && (state_reg != par_pkg::PAR_ST_IDLE)
                      && (state_next == par_pkg::PAR_ST_CHECK);
            if (tmrLoad && state_next == par_pkg::PAR_ST_CHECK) begin
                chkData.keyAddr <= keyPtr_reg
                    + {23'h00_0000, (nextKey ? 5'(keyIdx_reg + 5'h01) : 5'h00),
                       4'h0};
                chkData.target_address_pointer <= target_address_pointer_reg;
                chkData.tempPtr <= tempPtr_reg;
            end
        end
    end

    par_slot_timer slotTimer (
        .ref_clk   (ref_clk),
        .nrst      (nrst),
        .load      (tmrLoad),
        .loadCount (tmrCount),
        .expired   (tmrExpired)
    );

    // cycles spent in the setup slot; the slot length is a parameter, so no fixed repetition
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            setupCnt_reg <= 16'h0000;
        end else if (state_reg == par_pkg::PAR_ST_SETUP) begin
            setupCnt_reg <= setupCnt_reg + 16'h0001;
        end else begin
            setupCnt_reg <= 16'h0000;
        end
    end

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence startSeq;
        state_reg == par_pkg::PAR_ST_IDLE && startHit && running && !stopHit;
    endsequence

    mask_clear_a: assert property ((wrEn && regHit(paddr, `PAR_OFF_MASKCLR) && pwdata[0])
        |=> !mask_reg[0]) else $error("mask clear ignored");
    mask_set_a: assert property ((wrEn && regHit(paddr, `PAR_OFF_MASKSET) && pwdata[2])
        |=> mask_reg[2]) else $error("mask set ignored");
    irq_level_a: assert property (##1 irq == $past(|(event_reg & mask_reg)))
        else $error("irq not tracking flags");
    end_pair_a: assert property (evSet[0] |-> (evSet[1] ^ evSet[2]))
        else $error("done without exactly one outcome");
    status_update_a: assert property (evSet[1] |=> status_reg == $past(keyIdx_reg[3:0]))
        else $error("status not updated on match");
    disabled_idle_a: assert property (!running |=> state_reg == par_pkg::PAR_ST_IDLE)
        else $error("resolver active while disabled");
    stop_abort_a: assert property (stopHit |=> state_reg == par_pkg::PAR_ST_IDLE
        && !event_reg[0] || $past(event_reg[0])) else $error("stop did not abort");
    start_run_a: assert property (startSeq |=> state_reg == par_pkg::PAR_ST_SETUP)
        else $error("start not taken");
    key_bound_a: assert property (state_reg == par_pkg::PAR_ST_CHECK
        |-> keyIdx_reg < keyCount_reg) else $error("key index beyond count");
    setup_hold_a: assert property ((state_reg == par_pkg::PAR_ST_SETUP && !stopHit
        && running && state_next != par_pkg::PAR_ST_SETUP)
        |-> setupCnt_reg == 16'(SETUP_CYC)) else $error("setup slot wrong length");

endmodule // par_resolver_top

`default_nettype wire

// ### tb/par_matcher_model.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// key matcher standing in for ram and the compare engine
module par_matcher_model (
    input  wire logic                  ref_clk,
    input  wire logic                  nrst,
    input  wire logic                  chkReq,
    input  wire par_pkg::par_chk_req_t chkData,
    input  wire logic [31:0]           hitAddr,
    input  wire logic [3:0]            answerDelay,
    output logic                       chkDone,
    output logic                       chkMatch
);
    logic       busy;
    logic       hit;
    logic [3:0] waitCnt;

    // one answer per request, after a delay that may outlast the slot
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            busy     <= 1'b0;
            hit      <= 1'b0;
            waitCnt  <= 4'h0;
            chkDone  <= 1'b0;
            chkMatch <= 1'b0;
        end else begin
            chkDone  <= 1'b0;
            chkMatch <= ~chkMatch; // idle line toggles, never a stale answer
            if (chkReq) begin
                busy    <= 1'b1;
                hit     <= (chkData.keyAddr == hitAddr);
                waitCnt <= answerDelay;
            end else if (busy) begin
                if (waitCnt == 4'h0) begin
                    busy     <= 1'b0;
                    chkDone  <= 1'b1;
                    chkMatch <= hit;
                end else begin
                    waitCnt <= waitCnt - 4'h1;
                end
            end
        end
    end
endmodule // par_matcher_model

`default_nettype wire

// ### tb/par_resolver_top_bench.sv
`timescale 1ns/1ns
`default_nettype none

module par_resolver_top_bench;
    localparam int SETUP = 2;
    localparam int SLOT  = 3;
    logic                  ref_clk;
    logic                  nrst;
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [11:0]           paddr;
    logic [31:0]           pwdata;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  irq;
    logic                  chkReq;
    logic                  chkDone;
    logic                  chkMatch;
    par_pkg::par_chk_req_t chkData;
    logic [31:0]           hitAddr;
    logic [31:0]           keyBase;
    logic [31:0]           rd;
    logic                  err;
    logic [3:0]            answerDelay;
    int                    badCount = 0;
    int                    checksDone = 0;
    int                    cycles = 0;
    int                    reqCount = 0;
    int                    t;
    logic [11:0]           rstAddr [8] = '{12'h304, 12'h308, 12'h400, 12'h500,
                                           12'h504, 12'h508, 12'h510, 12'h514};
    logic [31:0]           rstVal [8] = '{32'h0, 32'h0, 32'h0, 32'h0,
                                          32'h1, 32'h0, 32'h0, 32'h0};

    par_resolver_top #(.SETUP_CYC(SETUP), .KEY_CYC(SLOT)) par_resolver_top_inst (
        .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .chkReq(chkReq),
        .chkData(chkData), .chkDone(chkDone), .chkMatch(chkMatch)
    );

    par_matcher_model par_matcher_model_inst (
        .ref_clk(ref_clk), .nrst(nrst), .chkReq(chkReq), .chkData(chkData),
        .hitAddr(hitAddr), .answerDelay(answerDelay), .chkDone(chkDone),
        .chkMatch(chkMatch)
    );

    // ==========================================================
    // clock and hang guard
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    // ceiling well above the few hundred cycles the tests need
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            badCount++;
            testDone();
        end
    end

    // ==========================================================
    // shared tasks
    task automatic testDone();
        $display("checks %0d mismatches %0d", checksDone, badCount);
        if (badCount == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checksDone++;
        if (got !== exp) begin
            badCount++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one apb transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) check(32'h0, 32'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // poll the done flag, bounded
    task automatic waitDone();
        int k;
        k = 0;
        do begin
            xfer(1'b0, 12'h100, 32'h0);
            k++;
        end while (rd !== 32'h1 && k < 100);
    endtask

    task automatic clearEvents();
        wr(12'h100, 32'h1);
        wr(12'h104, 32'h1);
        wr(12'h108, 32'h1);
    endtask

    // every key request carries the programmed pointers
    always @(posedge ref_clk) begin
        if (chkReq === 1'b1) begin
            check(chkData.keyAddr, keyBase + 32'(reqCount) * 32'h10);
            check(chkData.target_address_pointer, 32'h2000_0200);
            check(chkData.tempPtr, 32'h2000_0300);
            reqCount++;
        end
    end

    // ==========================================================
    // test sequence
    initial begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h0; pwdata = 32'h0; answerDelay = 4'h1;
        hitAddr = 32'hffff_fff0; keyBase = 32'h2000_0100;
        repeat (8) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) rdChk(rstAddr[i], rstVal[i]);
        xfer(1'b0, 12'h600, 32'h0);
        check(rd, 32'h0);
        check(32'(err), 32'h1);
        $display("test reset values done");
        wr(12'h508, 32'h2000_0100);
        rdChk(12'h508, 32'h2000_0100);
        wr(12'h510, 32'h2000_0200);
        rdChk(12'h510, 32'h2000_0200);
        wr(12'h514, 32'h2000_0300);
        wr(12'h400, 32'h0000_000f);
        rdChk(12'h400, 32'h0);
        wr(12'h504, 32'h4);
        rdChk(12'h504, 32'h4);
        wr(12'h500, 32'h3);
        rdChk(12'h500, 32'h3);
        wr(12'h304, 32'h7);
        rdChk(12'h304, 32'h7);
        wr(12'h308, 32'h2);
        rdChk(12'h308, 32'h5);
        rdChk(12'h304, 32'h5);
        $display("test registers done");
        hitAddr = 32'h2000_0120;
        reqCount = 0;
        wr(12'h000, 32'h1);
        waitDone();
        rdChk(12'h104, 32'h1);
        rdChk(12'h108, 32'h0);
        rdChk(12'h400, 32'h2);
        check(32'(irq), 32'h1);
        wr(12'h308, 32'h7);
        @(negedge ref_clk);
        check(32'(irq), 32'h0);
        @(posedge ref_clk);
        clearEvents();
        rdChk(12'h100, 32'h0);
        $display("test match done");
        hitAddr = 32'hffff_fff0;
        wr(12'h504, 32'h3);
        wr(12'h304, 32'h1);
        reqCount = 0;
        wr(12'h000, 32'h1);
        t = 0;
        while (irq !== 1'b1 && t < 500) begin
            @(posedge ref_clk);
            t++;
        end
        check(32'(t >= SETUP + 3 * SLOT), 32'h1);
        check(32'(t <= SETUP + 3 * (SLOT + 4) + 4), 32'h1);
        check(32'(reqCount), 32'h3);
        rdChk(12'h108, 32'h1);
        rdChk(12'h104, 32'h0);
        rdChk(12'h400, 32'h2);
        clearEvents();
        $display("test no match done");
        answerDelay = 4'h8;
        wr(12'h504, 32'h10);
        reqCount = 0;
        wr(12'h000, 32'h1);
        repeat (20) @(posedge ref_clk);
        wr(12'h008, 32'h1);
        t = reqCount;
        repeat (100) @(posedge ref_clk);
        check(32'(reqCount), 32'(t));
        rdChk(12'h100, 32'h0);
        $display("test abort done");
        wr(12'h500, 32'h0);
        rdChk(12'h500, 32'h0);
        reqCount = 0;
        wr(12'h000, 32'h1);
        repeat (40) @(posedge ref_clk);
        check(32'(reqCount), 32'h0);
        rdChk(12'h100, 32'h0);
        $display("test disabled start done");
        testDone();
    end
endmodule // par_resolver_top_bench

`default_nettype wire
